//--- rtl/pvc_cal_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pvc_params.svh"

module pvc_cal_ctrl
   import pvc_pkg::*;
#(
   parameter int SETTLE_BASE_CYC = `PVC_SETTLE_BASE_CYC
)
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Register port.
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Oscillator and PLL side.
   input  wire logic       osc_above_target,
   output logic      [6:0] oscillator_tune_code,
   output logic            pll_program_hold,
   output logic            osc_calibration_busy
);

   // Settle base count sized to the timer's width.
   localparam logic [15:0] BASE_CYC = 16'(SETTLE_BASE_CYC);

   pvc_state_type state_q;
   pvc_state_type state_d;
   logic [6:0]    tune_q;
   logic [6:0]    tune_d;
   logic [2:0]    bit_q;
   logic [2:0]    bit_d;
   logic          hold_q;
   logic          hold_d;
   logic          enable_q;
   logic          enable_d;
   logic [2:0]    settle_q;
   logic [2:0]    settle_d;
   logic          complete_q;
   logic          complete_d;
   logic [7:0]    rdata_d;
   logic          timer_start;
   logic          timer_expired;
   logic [15:0]   settle_cycles;
   logic          wr_tune;
   logic          wr_hold;
   logic          wr_ctrl;
   logic          release_hold;

   // Write strobes decoded per register.
   assign wr_tune      = reg_wr && (reg_addr == `PVC_ADDR_TUNE_CODE);
   assign wr_hold      = reg_wr && (reg_addr == `PVC_ADDR_PROGRAM_HOLD);
   assign wr_ctrl      = reg_wr && (reg_addr == `PVC_ADDR_CAL_CONTROL);
   assign release_hold = wr_hold && hold_q && !reg_wdata[`PVC_HOLD_BIT];

   // Settle wait doubles with each step of the select.
   assign settle_cycles = BASE_CYC << settle_q;

   // Settle timer, restarted when a run starts and after each decided bit but the last.
   pvc_settle_timer u_settle_timer
   (
      .clk        (clk),
      .rst_b      (rst_b),
      .start      (timer_start),
      .load_value (settle_cycles),
      .expired    (timer_expired)
   );

   // Register writes and the search engine.
   always_comb
   begin
      state_d     = state_q;
      tune_d      = tune_q;
      bit_d       = bit_q;
      hold_d      = hold_q;
      enable_d    = enable_q;
      settle_d    = settle_q;
      complete_d  = complete_q;
      timer_start = 1'b0;
      if (wr_hold)
      begin
         hold_d = reg_wdata[`PVC_HOLD_BIT];
      end
      if (wr_ctrl)
      begin
         enable_d = reg_wdata[`PVC_CAL_ENABLE_BIT];
         settle_d = reg_wdata[`PVC_SETTLE_MSB:`PVC_SETTLE_LSB];
      end
      // Software trim writes are taken only while no run is active.
      if (wr_tune && (state_q == PVC_IDLE))
      begin
         tune_d = reg_wdata[`PVC_TUNE_MSB:0];
      end
      case (state_q)
         PVC_IDLE:
         begin
            if (release_hold)
            begin
               if (enable_q)
               begin
                  tune_d      = `PVC_TUNE_MID;
                  bit_d       = 3'h6;
                  timer_start = 1'b1;
                  complete_d  = 1'b0;
                  state_d     = PVC_SETTLE;
               end
               else
               begin
                  complete_d = 1'b1;
               end
            end
         end
         PVC_SETTLE:
         begin
            if (timer_expired)
            begin
               state_d = PVC_DECIDE;
            end
         end
         PVC_DECIDE:
         begin
            if (osc_above_target)
            begin
               tune_d[bit_q] = 1'b0;
            end
            if (bit_q == 3'h0)
            begin
               complete_d = 1'b1;
               state_d    = PVC_IDLE;
            end
            else
            begin
               bit_d              = bit_q - 3'h1;
               tune_d[bit_q - 3'h1] = 1'b1;
               timer_start        = 1'b1;
               state_d            = PVC_SETTLE;
            end
         end
         default:
         begin
            state_d = PVC_IDLE;
         end
      endcase
      // Holding the PLL aborts any run and clears completion.
      if (wr_hold && reg_wdata[`PVC_HOLD_BIT])
      begin
         complete_d = 1'b0;
         state_d    = PVC_IDLE;
      end
   end

   // Read data, registered one cycle after the read strobe.
   always_comb
   begin
      rdata_d = 8'h00;
      case (reg_addr)
         `PVC_ADDR_TUNE_CODE:    rdata_d = {1'b0, tune_q};
         `PVC_ADDR_PROGRAM_HOLD: rdata_d = {7'h00, hold_q};
         `PVC_ADDR_CAL_CONTROL:  rdata_d = {1'b0, settle_q, 3'h0, enable_q};
         `PVC_ADDR_CAL_STATE:    rdata_d = {7'h00, complete_q};
         default:                rdata_d = 8'h00;
      endcase
   end

   // Engine and register state.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q    <= PVC_IDLE;
         tune_q     <= `PVC_RST_TUNE_CODE;
         bit_q      <= 3'h0;
         hold_q     <= `PVC_RST_HOLD;
         enable_q   <= `PVC_RST_CAL_ENABLE;
         settle_q   <= `PVC_RST_SETTLE_SELECT;
         complete_q <= `PVC_RST_COMPLETE;
         reg_rdata  <= 8'h00;
      end
      else
      begin
         state_q    <= state_d;
         tune_q     <= tune_d;
         bit_q      <= bit_d;
         hold_q     <= hold_d;
         enable_q   <= enable_d;
         settle_q   <= settle_d;
         complete_q <= complete_d;
         if (reg_rd)
         begin
            reg_rdata <= rdata_d;
         end
      end
   end

   // Trim code and hold come straight from the registers; busy is decoded from the state.
   assign oscillator_tune_code = tune_q;
   assign pll_program_hold     = hold_q;
   assign osc_calibration_busy = (state_q != PVC_IDLE);

endmodule : pvc_cal_ctrl

`default_nettype wire

//--- rtl/pvc_params.svh
`ifndef PVC_PARAMS_SVH
`define PVC_PARAMS_SVH

// Register offsets on the device register port.
`define PVC_ADDR_TUNE_CODE      8'h59
`define PVC_ADDR_PROGRAM_HOLD   8'h5C
`define PVC_ADDR_CAL_CONTROL    8'h5D
`define PVC_ADDR_CAL_STATE      8'h5E

// Field positions.
`define PVC_TUNE_MSB            6
`define PVC_HOLD_BIT            0
`define PVC_CAL_ENABLE_BIT      0
`define PVC_SETTLE_LSB          4
`define PVC_SETTLE_MSB          6
`define PVC_COMPLETE_BIT        0

// Reset values.
`define PVC_RST_TUNE_CODE       7'h00
`define PVC_RST_HOLD            1'b0
`define PVC_RST_CAL_ENABLE      1'b0
`define PVC_RST_SETTLE_SELECT   3'h4
`define PVC_RST_COMPLETE        1'b0

// Timing: settle time for select 0, doubled for each step of the select.
`define PVC_CLK_PERIOD_PS       4000
`define PVC_SETTLE_BASE_NS      256
`define PVC_SETTLE_BASE_CYC     ((`PVC_SETTLE_BASE_NS * 1000) / `PVC_CLK_PERIOD_PS)

// Search start point: the top bit of the trim code.
`define PVC_TUNE_MID            7'h40

`endif

//--- rtl/pvc_pkg.sv
package pvc_pkg;

   typedef enum logic [1:0]
   {
      PVC_IDLE,
      PVC_SETTLE,
      PVC_DECIDE
   } pvc_state_type;

endpackage : pvc_pkg

//--- rtl/pvc_settle_timer.sv
`timescale 1ns/1ps
`default_nettype none

module pvc_settle_timer
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Control.
   input  wire logic        start,
   input  wire logic [15:0] load_value,
   // Status.
   output logic             expired
);

   logic [15:0] count_q;
   logic [15:0] count_d;
   logic        busy_q;
   logic        busy_d;
   logic        expired_d;

   always_comb
   begin
      count_d   = count_q;
      busy_d    = busy_q;
      expired_d = 1'b0;
      if (start)
      begin
         count_d = load_value;
         busy_d  = 1'b1;
      end
      else if (busy_q)
      begin
         if (count_q <= 16'h0001)
         begin
            busy_d    = 1'b0;
            expired_d = 1'b1;
         end
         else
         begin
            count_d = count_q - 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_q <= 16'h0000;
         busy_q  <= 1'b0;
         expired <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         busy_q  <= busy_d;
         expired <= expired_d;
      end
   end

endmodule : pvc_settle_timer

`default_nettype wire

//--- dv/pvc_cal_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module pvc_cal_monitor
(
   // Clock and reset.
   input wire logic       clk,
   input wire logic       rst_b,
   // Register port.
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Oscillator and PLL side.
   input wire logic       osc_above_target,
   input wire logic [6:0] oscillator_tune_code,
   input wire logic       pll_program_hold,
   input wire logic       osc_calibration_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_hold_write: assert property (reg_wr && reg_addr == 8'h5C |=> pll_program_hold == $past(reg_wdata[0]))
      else $error("hold bit not written");
   a_hold_read: assert property (reg_rd && reg_addr == 8'h5C |=> reg_rdata == {7'h00, $past(pll_program_hold)})
      else $error("hold read wrong");
   a_run_cause: assert property ($rose(osc_calibration_busy) |-> $past(reg_wr && reg_addr == 8'h5C && !reg_wdata[0]))
      else $error("run started without release");
   a_run_start: assert property ($rose(osc_calibration_busy) |-> oscillator_tune_code == 7'h40 && !pll_program_hold)
      else $error("run start code wrong");
   a_held_idle: assert property (pll_program_hold |-> !osc_calibration_busy)
      else $error("engine busy while held");
   a_run_settles: assert property ($rose(osc_calibration_busy) |-> osc_calibration_busy [*8])
      else $error("run ended too soon");
   a_tune_write: assert property (reg_wr && reg_addr == 8'h59 && !osc_calibration_busy
                                  |=> oscillator_tune_code == $past(reg_wdata[6:0]))
      else $error("trim write lost");
   a_tune_read: assert property (reg_rd && reg_addr == 8'h59 |=> reg_rdata == {1'b0, $past(oscillator_tune_code)})
      else $error("trim read wrong");
   a_state_rsvd: assert property (reg_rd && reg_addr == 8'h5E |=> reg_rdata[7:1] == 7'h00)
      else $error("status reserved bits set");
endmodule : pvc_cal_monitor

bind pvc_cal_ctrl pvc_cal_monitor pvc_cal_monitor_inst (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
   .reg_rdata, .osc_above_target, .oscillator_tune_code, .pll_program_hold, .osc_calibration_busy);

`default_nettype wire

//--- dv/test_pll_vco_calibration_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_pll_vco_calibration_control;
   logic       clk;
   logic       rst_b;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [6:0] tune;
   logic       hold;
   logic       busy;
   logic [6:0] target;
   int         n_fail;
   int         tests_run;
   int         cycles;
   int         n0;
   int         n2;

   pvc_cal_ctrl #(.SETTLE_BASE_CYC(2)) pvc_cal_ctrl_inst
   (
      .clk                  (clk),
      .rst_b                (rst_b),
      .reg_wr               (reg_wr),
      .reg_rd               (reg_rd),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_rdata            (reg_rdata),
      .osc_above_target     (tune > target),
      .oscillator_tune_code (tune),
      .pll_program_hold     (hold),
      .osc_calibration_busy (busy)
   );

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      if (n_fail == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      @(posedge clk);
      #1;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      chk(reg_rdata, exp);
      @(posedge clk);
      #1;
   endtask : rd_chk

   task automatic run_cal(input logic [2:0] sel, input logic [6:0] tgt, output int n);
      target = tgt;
      wr(8'h5C, 8'h01);
      chk({7'h00, hold}, 8'h01);
      wr(8'h5D, {1'b0, sel, 4'h1});
      repeat (4) @(posedge clk);
      #1;
      chk({7'h00, busy}, 8'h00);
      rd_chk(8'h5E, 8'h00);
      wr(8'h5C, 8'h00);
      chk({7'h00, hold}, 8'h00);
      chk({7'h00, busy}, 8'h01);
      n = 0;
      while (busy === 1'b1 && n < 5000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({7'h00, busy}, 8'h00);
      chk({1'b0, tune}, {1'b0, tgt});
      rd_chk(8'h5E, 8'h01);
      rd_chk(8'h59, {1'b0, tgt});
   endtask : run_cal

   task automatic t_reset;
      rd_chk(8'h5C, 8'h00);
      rd_chk(8'h5D, 8'h40);
      rd_chk(8'h5E, 8'h00);
      rd_chk(8'h00, 8'h00);
   endtask : t_reset

   task automatic t_tune_rw;
      wr(8'h59, 8'h7F);
      rd_chk(8'h59, 8'h7F);
      wr(8'h59, 8'h2A);
      rd_chk(8'h59, 8'h2A);
   endtask : t_tune_rw

   task automatic t_skip;
      wr(8'h5C, 8'h01);
      wr(8'h5D, 8'h00);
      rd_chk(8'h5E, 8'h00);
      wr(8'h5C, 8'h00);
      chk({7'h00, busy}, 8'h00);
      rd_chk(8'h5E, 8'h01);
      rd_chk(8'h59, 8'h2A);
   endtask : t_skip

   task automatic t_runs;
      run_cal(3'h0, 7'h5B, n0);
      run_cal(3'h2, 7'h00, n2);
      chk({7'h00, n2 > n0}, 8'h01);
      wr(8'h59, 8'h5B);
      rd_chk(8'h59, 8'h5B);
   endtask : t_runs

   initial
   begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      target = 7'h00;
      n_fail = 0;
      tests_run = 0;
      repeat (2) @(posedge clk);
      #1;
      rst_b = 1'b1;
      t_reset();
      t_tune_rw();
      t_skip();
      t_runs();
      wrap_up();
   end
endmodule : test_pll_vco_calibration_control

`default_nettype wire
